// ===== dv/hbf_chain_ctrl_props.sv
`timescale 1ns/1ps
module hbf_chain_ctrl_props
  import hbf_pkg::*;
(
  // Clock and bus
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  // Sync pin and outputs
  input wire logic        filter_sync_input,
  input wire hbf_cfg_t    cfg_out,
  input wire logic [4:0]  halfband_stage_active,
  input wire logic        filter_seq_reset,
  input wire logic        cfg_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Full-word writes only; lane merging is judged by the bench
  wire logic        wr = avs_write && avs_address == HBF_ADDR_CONFIG && &avs_byteenable;
  wire logic [31:0] d = avs_writedata;
  wire hbf_cfg_t    exp_cfg = {d[21:15], (d[14:11] == 4'h0) ? 5'h10 : {1'b0, d[14:11]}, d[10:0]};
  chk_sync_off: assert property (filter_sync_input ##1 !cfg_out.sync_en |-> !filter_seq_reset)
    else $error("sync off");
  chk_sync_on: assert property (filter_sync_input ##1 cfg_out.sync_en |-> filter_seq_reset)
    else $error("sync on");
  chk_bypass_idle: assert property (!cfg_out.hb_use && $stable(cfg_out) |-> halfband_stage_active == 5'h0)
    else $error("bypass");
  chk_stage_map: assert property (cfg_out.hb_use && $stable(cfg_out)
    |-> halfband_stage_active == cfg_out.stage_en) else $error("stages");
  chk_cfg_error: assert property ($past(resetn) && $stable(cfg_out)
    |-> cfg_error == (cfg_out.hb_use && cfg_out.stage_en == 5'h0 || cfg_out.fir_taps == 8'h0)) else $error("flag");
  chk_wr_decode: assert property (wr |=> ##1 cfg_out == $past(exp_cfg, 2)) else $error("decode");
  chk_final_stage: assert property (wr && d[20:19] == 2'h3 |=> ##2 halfband_stage_active[4]) else $error("final");
  chk_decim_zero: assert property (wr && d[14:11] == 4'h0 |=> ##1 cfg_out.fir_decim == 5'h10) else $error("dec");
endmodule

bind hbf_chain_ctrl hbf_chain_ctrl_props u_props (.*);

// ===== dv/hbf_chain_ctrl_tb_top.sv
`timescale 1ns/1ps
module hbf_chain_ctrl_tb_top
  import hbf_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, filter_sync_input = 1'b0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, filter_seq_reset, cfg_error;
  logic [4:0]  halfband_stage_active;
  hbf_cfg_t    cfg_out;
  int          err_total = 0, check_count = 0;
  hbf_chain_ctrl uut (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Called just after a rising edge; one idle edge follows so back-to-back calls never reassign in one step
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= we;
    avs_read <= !we;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] ecfg(input logic [31:0] w);
    ecfg = {9'h0, w[21:15], (w[14:11] == 4'h0) ? 5'h10 : {1'b0, w[14:11]}, w[10:0]};
  endfunction
  task automatic t_fields;
    logic [31:0] w;
    bus(1'b0, HBF_ADDR_CONFIG, 32'h0, 4'hf);
    chk({9'h0, cfg_out}, ecfg(32'h1));
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    chk(q, 32'h0);
    for (int i = 0; i < 34; i++)
    begin
      w = (i < 32) ? (32'h1 << i) | 32'h1 : ((i == 32) ? 32'h0 : 32'h0018_5a03);
      bus(1'b1, HBF_ADDR_CONFIG, w, 4'hf);
      bus(1'b0, HBF_ADDR_CONFIG, 32'h0, 4'hf);
      chk(q, w & 32'h003f_ffff);
      chk({9'h0, cfg_out}, ecfg(w));
      chk({27'h0, halfband_stage_active}, w[20] ? {27'h0, w[19:15]} : 32'h0);
      chk({31'h0, cfg_error}, {31'h0, w[20] && w[19:15] == 5'h0 || w[7:0] == 8'h0});
      bus(1'b0, HBF_ADDR_STATUS, 32'h0, 4'hf);
      chk(q, {22'h0, w[20] && w[19:15] == 5'h0 || w[7:0] == 8'h0, 1'b0,
              w[20] ? 3'($countones(w[19:15])) : 3'h0, w[20] ? w[19:15] : 5'h00});
    end
    bus(1'b1, HBF_ADDR_CONFIG, 32'hffff_ffff, 4'h2);
    bus(1'b0, HBF_ADDR_CONFIG, 32'h0, 4'hf);
    chk(q, 32'h0018_ff03);
  endtask
  task automatic t_sync(input logic en);
    bus(1'b1, HBF_ADDR_CONFIG, {10'h0, en, 21'h1}, 4'hf);
    @(posedge clk);
    filter_sync_input <= 1'b1;
    @(posedge clk);
    filter_sync_input <= 1'b0;
    @(posedge clk);
    chk({31'h0, filter_seq_reset}, {31'h0, en});
    bus(1'b0, HBF_ADDR_SYNC_CNT, 32'h0, 4'hf);
    chk(q, {31'h0, en});
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_fields;
    t_sync(1'b0);
    t_sync(1'b1);
    give_verdict;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    give_verdict;
  end
endmodule

// ===== src/hbf_chain_ctrl.sv
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Sync pin ignored when bit 21 clear
// - Sync pin resets filter sequencing when enabled
// - Bit 20 selects cascade, clear bypasses; software enables one
// - Bit 19 includes final halfband stage
// - Bits 18-15 enable stages four to one
// - Bits 14-11 decimation, zero means sixteen
// - Bit 10: complex or dual real
// - Bit 9: odd or even symmetry
// - Bit 8: symmetric or asymmetric coefficients
// - Bits 7-0 tap count, zero invalid
module hbf_chain_ctrl
  import hbf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // External filter synchronisation pin
  input  wire logic        filter_sync_input,
  // Configuration to the filter datapath
  output hbf_cfg_t         cfg_out,
  output logic [4:0]       halfband_stage_active,
  output logic             filter_seq_reset,
  output logic             cfg_error
);

  logic [31:0] config_reg;
  logic [31:0] config_next;
  logic [31:0] readdata_reg;
  logic        rd_done_reg;
  logic        seq_reset_reg;
  logic [15:0] sync_cnt_reg;
  hbf_cfg_t    cfg;
  hbf_path_t   path;
  logic        wr_cfg;
  logic        sync_hit;

  hbf_decode u_decode
  (
    .cfg_word (config_reg),
    .cfg      (cfg)
  );

  hbf_stage_path u_path
  (
    .cfg  (cfg),
    .path (path)
  );

  // Writes complete with no wait; reads wait one cycle for registered data
  assign avs_waitrequest = avs_read & ~rd_done_reg;
  assign wr_cfg          = avs_write && (avs_address == HBF_ADDR_CONFIG);

  always_comb
  begin
    config_next = config_reg;
    for (int b = 0; b < 4; b++)
    begin
      if (avs_byteenable[b])
        config_next[b*8 +: 8] = avs_writedata[b*8 +: 8];
    end
    config_next = config_next & HBF_CONFIG_MASK;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      config_reg <= HBF_CONFIG_RESET;
    else if (wr_cfg)
      config_reg <= config_next;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_done_reg  <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end
    else
    begin
      rd_done_reg <= avs_read & ~rd_done_reg;
      if (avs_read && !rd_done_reg)
      begin
        case (avs_address)
          HBF_ADDR_CONFIG:   readdata_reg <= config_reg & HBF_CONFIG_MASK;
          HBF_ADDR_STATUS:   readdata_reg <= {21'h0, filter_seq_reset, path.cfg_error,
                                              1'b0, path.stage_count, path.stage_active};
          HBF_ADDR_SYNC_CNT: readdata_reg <= {16'h0, sync_cnt_reg};
          default:           readdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin acts only when enabled; otherwise sequencing never sees it
  assign sync_hit = cfg.sync_en & filter_sync_input;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      seq_reset_reg <= 1'b0;
    else
      seq_reset_reg <= sync_hit;
  end

  // Counts accepted sync events for alignment checks, saturating
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sync_cnt_reg <= 16'h0000;
    else if (sync_hit && sync_cnt_reg != 16'hffff)
      sync_cnt_reg <= sync_cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_out               <= '0;
      halfband_stage_active <= 5'h00;
      cfg_error             <= 1'b0;
    end
    else
    begin
      cfg_out               <= cfg;
      halfband_stage_active <= path.stage_active;
      cfg_error             <= path.cfg_error;
    end
  end

  assign avs_readdata     = readdata_reg;
  assign filter_seq_reset = seq_reset_reg;

endmodule

// ===== src/hbf_decode.sv
`timescale 1ns/1ps
module hbf_decode
  import hbf_pkg::*;
(
  // Raw configuration word
  input  wire logic [31:0] cfg_word,
  // Decoded fields
  output hbf_cfg_t         cfg
);

  always_comb
  begin
    cfg.sync_en       = cfg_word[HBF_BIT_SYNC_EN];
    cfg.hb_use        = cfg_word[HBF_BIT_HB_USE];
    cfg.stage_en      = cfg_word[HBF_BIT_FINAL_EN:HBF_LSB_STAGE_EN];
    cfg.fir_dual_real = cfg_word[HBF_BIT_REAL];
    cfg.fir_even_sym  = cfg_word[HBF_BIT_SYM_TYPE];
    cfg.fir_asym      = cfg_word[HBF_BIT_ASYM];
    cfg.fir_taps      = cfg_word[HBF_MSB_TAPS:0];
    // Code zero stands for the largest factor
    if (cfg_word[HBF_MSB_DEC:HBF_LSB_DEC] == 4'h0)
      cfg.fir_decim = HBF_DEC_ZERO_VAL;
    else
      cfg.fir_decim = {1'b0, cfg_word[HBF_MSB_DEC:HBF_LSB_DEC]};
  end

endmodule

// ===== src/hbf_pkg.sv
package hbf_pkg;

  // Register map, byte addresses on the Avalon-MM word bus
  localparam logic [3:0]  HBF_ADDR_CONFIG   = 4'h0;
  localparam logic [3:0]  HBF_ADDR_STATUS   = 4'h4;
  localparam logic [3:0]  HBF_ADDR_SYNC_CNT = 4'h8;

  // Configuration word field positions
  localparam int HBF_BIT_SYNC_EN    = 21;
  localparam int HBF_BIT_HB_USE     = 20;
  localparam int HBF_BIT_FINAL_EN   = 19;
  localparam int HBF_LSB_STAGE_EN   = 15;
  localparam int HBF_MSB_STAGE_EN   = 18;
  localparam int HBF_LSB_DEC        = 11;
  localparam int HBF_MSB_DEC        = 14;
  localparam int HBF_BIT_REAL       = 10;
  localparam int HBF_BIT_SYM_TYPE   = 9;
  localparam int HBF_BIT_ASYM       = 8;
  localparam int HBF_MSB_TAPS       = 7;
  localparam int HBF_MSB_IMPL       = 21;

  // Value after reset and the mask of implemented bits
  localparam logic [31:0] HBF_CONFIG_RESET = 32'h0000_0001;
  localparam logic [31:0] HBF_CONFIG_MASK  = 32'h003f_ffff;

  localparam int          HBF_NUM_STAGES   = 5;
  localparam logic [4:0]  HBF_DEC_ZERO_VAL = 5'h10;
  localparam logic [1:0]  HBF_RD_LATENCY   = 2'h1;

  typedef struct packed {
    logic       sync_en;
    logic       hb_use;
    logic [4:0] stage_en;
    logic [4:0] fir_decim;
    logic       fir_dual_real;
    logic       fir_even_sym;
    logic       fir_asym;
    logic [7:0] fir_taps;
  } hbf_cfg_t;

  typedef struct packed {
    logic [4:0] stage_active;
    logic [2:0] stage_count;
    logic       cfg_error;
  } hbf_path_t;

endpackage

// ===== src/hbf_stage_path.sv
`timescale 1ns/1ps
module hbf_stage_path
  import hbf_pkg::*;
(
  // Decoded configuration
  input  hbf_cfg_t  cfg,
  // Resulting decimation path
  output hbf_path_t path
);

  logic [4:0] act;

  genvar g;
  generate
    for (g = 0; g < HBF_NUM_STAGES; g++)
    begin : g_stage
      // Bypass overrides every stage enable
      assign act[g] = cfg.hb_use & cfg.stage_en[g];
    end
  endgenerate

  always_comb
  begin
    path.stage_active = act;
    path.stage_count  = 3'(act[0]) + 3'(act[1]) + 3'(act[2]) + 3'(act[3]) + 3'(act[4]);
    // Cascade in use but empty, or a zero tap count: flagged, not corrected
    path.cfg_error    = (cfg.hb_use && (cfg.stage_en == 5'h00)) || (cfg.fir_taps == 8'h00);
  end

endmodule
